// [verilog/dcm_pkg.sv]
// Shared constants, types and rule summary of the audio core datapath
// Function
// - Audio sample words in and out: 24 bits
// - Inputs sign-extended from 24 to 28 bits
// - Four headroom bits give 24 dB gain
// - Parameters and data share signed 5.23
// - Range -16.0 up to just below 16.0
// - Value 1.0 stored as 0x00800000
// - Output clipped to 24 bits, -1..1-LSB
// - Default program passes through, outputs muted
// - All instruction slots run every sample at single rate
// - Fewer slots allow double and quad rate
// - Parameter memory 1024x32 at 0x000-0x3FF
// - Program memory 1024x40 at 0x400-0x7FF
// - Parameter words padded with four zeros
// - Memories reset zero, program gets default
// - Power-up fills memories from boot contents
// - Direct writes take parameter memory from core
// - Five safeload entries copied when memory idle
// - Safeload writes parameter memory only
// - Whole safeload set lands within one frame
// - Data memory 2k words, host cannot reach
// - Delays step whole samples over 2048 words
// - Burst accesses auto-increment across regions
package dcm_pkg;

    // ---------------------------------------------------------------
    // Widths and sizes
    // ---------------------------------------------------------------
    localparam int SAMP_W = 24;
    localparam int CORE_W = 28;
    localparam int FRAC_W = 23;
    localparam int PRAM_W = 32;
    localparam int PROG_W = 40;
    localparam int HADR_W = 12;
    localparam int PRAM_DEPTH = 1024;
    localparam int PROG_DEPTH = 1024;
    localparam int DRAM_DEPTH = 2048;
    localparam int SL_ENTRIES = 5;

    // ---------------------------------------------------------------
    // Host address map
    // ---------------------------------------------------------------
    localparam logic [11:0] PRAM_LAST = 12'h3FF;
    localparam logic [11:0] PROG_BASE = 12'h400;
    localparam logic [11:0] PROG_LAST = 12'h7FF;

    // ---------------------------------------------------------------
    // Fixed-point values and clip limits
    // ---------------------------------------------------------------
    localparam logic [31:0] PRAM_ONE = 32'h00800000;
    localparam logic [27:0] FX_MAX = 28'h7FFFFFF;
    localparam logic [27:0] FX_MIN = 28'h8000000;
    localparam logic [23:0] OUT_MAX = 24'h7FFFFF;
    localparam logic [23:0] OUT_MIN = 24'h800000;

    // ---------------------------------------------------------------
    // Last instruction slot per rate setting, and last boot fill index
    // ---------------------------------------------------------------
    localparam logic [9:0] LAST_X1 = 10'h3FF;
    localparam logic [9:0] LAST_X2 = 10'h1FF;
    localparam logic [9:0] LAST_X4 = 10'h0FF;
    localparam logic [10:0] INIT_LAST = 11'h7FF;

    // ---------------------------------------------------------------
    // Instruction word fields and opcodes
    // ---------------------------------------------------------------
    localparam int OP_MSB = 39;
    localparam int OP_LSB = 36;
    localparam int CH_BIT = 32;
    localparam int DA_MSB = 30;
    localparam int DA_LSB = 20;
    localparam int PA_MSB = 9;
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_LDIN = 4'h1;
    localparam logic [3:0] OP_LDD = 4'h2;
    localparam logic [3:0] OP_MULP = 4'h3;
    localparam logic [3:0] OP_ACCD = 4'h4;
    localparam logic [3:0] OP_STD = 4'h5;
    localparam logic [3:0] OP_OUT = 4'h6;

    // Default pass-through program, slots 0..3, rest no-op
    localparam logic [39:0] DEF_P0 = 40'h1000000000;
    localparam logic [39:0] DEF_P1 = 40'h6000000000;
    localparam logic [39:0] DEF_P2 = 40'h1100000000;
    localparam logic [39:0] DEF_P3 = 40'h6100000000;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_RUN, ST_SAFE} dcm_st_t;

    typedef struct packed {
        logic valid;
        logic first;
        logic wr;
        logic [11:0] addr;
        logic [39:0] wdata;
    } dcm_hreq_t;

    typedef struct packed {
        logic wr;
        logic [2:0] idx;
        logic [9:0] addr;
        logic [27:0] data;
        logic commit;
    } dcm_slreq_t;

    typedef struct packed {
        logic vld;
        logic [9:0] addr;
        logic [27:0] data;
    } dcm_slent_t;

endpackage

// [verilog/dcm_sext.sv]
// Sign extension of a serial-port sample to the core word
`timescale 1ns/100ps
module dcm_sext #(
    parameter int IN_W = 24,
    parameter int OUT_W = 28
) (
    input wire logic [IN_W-1:0] din,
    output logic [OUT_W-1:0] dout
);
    // Replicate sign into the headroom bits
    assign dout = {{(OUT_W-IN_W){din[IN_W-1]}}, din};
endmodule

// [verilog/dcm_clip.sv]
// Saturating clipper from the core word to the output sample
`timescale 1ns/100ps
module dcm_clip (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [27:0] din,
    output logic [23:0] dout
);
    // Top five bits all equal means the value fits
    logic fits;
    assign fits = (din[27:23] == 5'h00) || (din[27:23] == 5'h1F);

    // Saturate to the nearest limit instead of wrapping
    always_comb begin
        if (fits) begin
            dout = din[23:0];
        end else if (din[27]) begin
            dout = dcm_pkg::OUT_MIN;
        end else begin
            dout = dcm_pkg::OUT_MAX;
        end
    end

    a_clip_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!din[27] && !fits) |-> dout == 24'h7FFFFF)
        else $error("clip high not saturated");
    a_clip_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (din[27] && !fits) |-> dout == 24'h800000)
        else $error("clip low not saturated");
endmodule

// [verilog/dcm_core.sv]
// Audio core: memories, instruction pass, safeload, host access
`timescale 1ns/100ps
module dcm_core (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire dcm_pkg::dcm_hreq_t hreq,
    input wire dcm_pkg::dcm_slreq_t slreq,
    input wire logic samp_valid,
    input wire logic [23:0] samp_l,
    input wire logic [23:0] samp_r,
    input wire logic [1:0] rate_sel,
    input wire logic core_run,
    input wire logic unmute,
    output logic [23:0] out_l,
    output logic [23:0] out_r,
    output logic out_valid,
    output logic host_rvalid,
    output logic [39:0] host_rdata,
    output logic ready
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        dcm_pkg::dcm_st_t st;            // Sequencer state
        logic [10:0] ini;                // Boot fill index
        logic [9:0] pc;                  // Instruction slot
        logic [10:0] base;               // Delay ring origin
        logic [11:0] haddr;              // Burst address
        logic [27:0] acc;                // Accumulator
        logic [27:0] nl;                 // Newest left sample
        logic [27:0] nr;                 // Newest right sample
        logic [27:0] il;                 // Left sample of pass
        logic [27:0] ir;                 // Right sample of pass
        logic pend;                      // Sample waiting
        logic go;                        // Safeload committed
        dcm_pkg::dcm_slent_t [4:0] sl;   // Safeload entries
        logic [23:0] ol;                 // Left result
        logic [23:0] orr;                // Right result
        logic [23:0] out_l;              // Left output
        logic [23:0] out_r;              // Right output
        logic out_valid;                 // Frame strobe
        logic rvalid;                    // Read answer strobe
        logic [39:0] rdata;              // Read answer data
        logic ready;                     // Boot fill done
    } dcm_core_s_t;

    dcm_core_s_t s_q;
    dcm_core_s_t s_d;

    // ---------------------------------------------------------------
    // Memories
    // ---------------------------------------------------------------
    logic [31:0] pram_mem [dcm_pkg::PRAM_DEPTH];  // Parameters
    logic [39:0] prog_mem [dcm_pkg::PROG_DEPTH];  // Instructions
    logic [27:0] dram_mem [dcm_pkg::DRAM_DEPTH];  // Audio data

    // Write ports, driven combinationally
    logic pram_we;
    logic [9:0] pram_wa;
    logic [31:0] pram_wd;
    logic prog_we;
    logic [9:0] prog_wa;
    logic [39:0] prog_wd;
    logic dram_we;
    logic [10:0] dram_wa;
    logic [27:0] dram_wd;
    logic sl_we;

    // ---------------------------------------------------------------
    // Datapath helpers
    // ---------------------------------------------------------------
    logic [39:0] insn;         // Current instruction
    logic [3:0] op;            // Opcode
    logic ch;                  // Channel select
    logic [10:0] dphys;        // Physical data address after ring offset
    logic [27:0] dword;        // Data operand
    logic [27:0] core_par;     // Parameter seen by core
    logic [55:0] prod;         // Full product
    logic [27:0] mulv;         // Product back in 5.23
    logic [23:0] clip_v;       // Clipped accumulator
    logic [27:0] sx_l;         // Extended left input
    logic [27:0] sx_r;         // Extended right input
    logic [11:0] eaddr;        // Host effective address
    logic hact;                // Host access this cycle
    logic host_pwe;            // Host parameter write
    logic host_gwe;            // Host program write
    logic [9:0] last_pc;       // Last slot of pass
    logic [39:0] ini_word;     // Default program word
    logic [2:0] sl_sel;        // Entry being copied
    logic sl_any;              // Some entry valid

    assign insn = prog_mem[s_q.pc];
    assign op = insn[dcm_pkg::OP_MSB:dcm_pkg::OP_LSB];
    assign ch = insn[dcm_pkg::CH_BIT];
    // Ring offset makes a fixed address step back one sample per pass
    assign dphys = insn[dcm_pkg::DA_MSB:dcm_pkg::DA_LSB] + s_q.base;
    assign dword = dram_mem[dphys];

    // Input sign extension
    dcm_sext #(.IN_W(dcm_pkg::SAMP_W), .OUT_W(dcm_pkg::CORE_W)) u_sx_l (
        .din(samp_l),
        .dout(sx_l)
    );
    dcm_sext #(.IN_W(dcm_pkg::SAMP_W), .OUT_W(dcm_pkg::CORE_W)) u_sx_r (
        .din(samp_r),
        .dout(sx_r)
    );

    // Output clipping of the accumulator
    dcm_clip u_clip (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .din(s_q.acc),
        .dout(clip_v)
    );

    // Host decode; burst continues from the stored address
    assign hact = hreq.valid && (s_q.st != dcm_pkg::ST_INIT);
    assign eaddr = hreq.first ? hreq.addr : s_q.haddr;
    assign host_pwe = hact && hreq.wr && (eaddr <= dcm_pkg::PRAM_LAST);
    assign host_gwe = hact && hreq.wr && (eaddr >= dcm_pkg::PROG_BASE) &&
                      (eaddr <= dcm_pkg::PROG_LAST);

    // No handshake: a host write steals the parameter from the core
    assign core_par = host_pwe ? 28'h0000000 :
                      pram_mem[insn[dcm_pkg::PA_MSB:0]][27:0];

    // Signed 5.23 times 5.23 gives 10.46; keep the 5.23 slice
    assign prod = $signed(s_q.acc) * $signed(core_par);
    assign mulv = prod[50:23];

    // Instruction budget per rate setting
    always_comb begin
        unique case (rate_sel)
            2'b00: last_pc = dcm_pkg::LAST_X1;
            2'b01: last_pc = dcm_pkg::LAST_X2;
            default: last_pc = dcm_pkg::LAST_X4;
        endcase
    end

    // Boot contents of program memory
    always_comb begin
        unique case (s_q.ini)
            11'h000: ini_word = dcm_pkg::DEF_P0;
            11'h001: ini_word = dcm_pkg::DEF_P1;
            11'h002: ini_word = dcm_pkg::DEF_P2;
            11'h003: ini_word = dcm_pkg::DEF_P3;
            default: ini_word = 40'h0000000000;
        endcase
    end

    // Lowest valid safeload entry
    always_comb begin
        sl_sel = 3'h0;
        sl_any = 1'b0;
        for (int i = dcm_pkg::SL_ENTRIES - 1; i >= 0; i--) begin
            if (s_q.sl[i].vld) begin
                sl_sel = 3'(i);
                sl_any = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Memory write muxes
    // ---------------------------------------------------------------
    always_comb begin
        // Safeload only between passes, yields to host writes
        sl_we = (s_q.st == dcm_pkg::ST_SAFE) && sl_any && !host_pwe;
        pram_we = 1'b0;
        pram_wa = eaddr[9:0];
        pram_wd = {4'h0, hreq.wdata[27:0]};
        prog_we = 1'b0;
        prog_wa = eaddr[9:0];
        prog_wd = hreq.wdata;
        dram_we = 1'b0;
        dram_wa = dphys;
        dram_wd = s_q.acc;
        if (s_q.st == dcm_pkg::ST_INIT) begin
            // Boot fill: zero data, zero parameters, default program
            pram_we = !s_q.ini[10];
            pram_wa = s_q.ini[9:0];
            pram_wd = 32'h00000000;
            prog_we = !s_q.ini[10];
            prog_wa = s_q.ini[9:0];
            prog_wd = ini_word;
            dram_we = 1'b1;
            dram_wa = s_q.ini;
            dram_wd = 28'h0000000;
        end else begin
            if (host_pwe) begin
                pram_we = 1'b1;
            end else if (sl_we) begin
                pram_we = 1'b1;
                pram_wa = s_q.sl[sl_sel].addr;
                pram_wd = {4'h0, s_q.sl[sl_sel].data};
            end
            prog_we = host_gwe;
            dram_we = (s_q.st == dcm_pkg::ST_RUN) && (op == dcm_pkg::OP_STD);
        end
    end

    // Parameter memory port
    always_ff @(posedge ref_clk) begin
        if (pram_we) begin
            pram_mem[pram_wa] <= pram_wd;
        end
    end

    // Program memory port
    always_ff @(posedge ref_clk) begin
        if (prog_we) begin
            prog_mem[prog_wa] <= prog_wd;
        end
    end

    // Data memory port, internal use only
    always_ff @(posedge ref_clk) begin
        if (dram_we) begin
            dram_mem[dram_wa] <= dram_wd;
        end
    end

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.out_valid = 1'b0;
        s_d.rvalid = 1'b0;

        // Newest sample, held until a pass starts
        if (samp_valid) begin
            s_d.nl = sx_l;
            s_d.nr = sx_r;
            s_d.pend = 1'b1;
        end

        // Host read answer and burst increment
        if (hact) begin
            s_d.haddr = eaddr + 12'h001;
            if (!hreq.wr) begin
                s_d.rvalid = 1'b1;
                if (eaddr <= dcm_pkg::PRAM_LAST) begin
                    s_d.rdata = {8'h00, 4'h0, pram_mem[eaddr[9:0]][27:0]};
                end else if (eaddr <= dcm_pkg::PROG_LAST) begin
                    s_d.rdata = prog_mem[eaddr[9:0]];
                end else begin
                    s_d.rdata = 40'h0000000000;
                end
            end
        end

        // Safeload loading and commit
        if (slreq.commit) begin
            s_d.go = 1'b1;
        end
        if (sl_we) begin
            s_d.sl[sl_sel].vld = 1'b0;
        end
        if (slreq.wr && (slreq.idx < 3'(dcm_pkg::SL_ENTRIES))) begin
            // A fresh load beats the copy clearing it
            s_d.sl[slreq.idx].vld = 1'b1;
            s_d.sl[slreq.idx].addr = slreq.addr;
            s_d.sl[slreq.idx].data = slreq.data;
        end

        // Output mute follows the input at once
        if (!unmute) begin
            s_d.out_l = 24'h000000;
            s_d.out_r = 24'h000000;
        end

        unique case (s_q.st)
            dcm_pkg::ST_INIT: begin
                // Walk all data words, first half covers both RAMs
                s_d.ini = s_q.ini + 11'h001;
                if (s_q.ini == dcm_pkg::INIT_LAST) begin
                    s_d.st = dcm_pkg::ST_IDLE;
                    s_d.ready = 1'b1;
                end
            end
            dcm_pkg::ST_IDLE: begin
                // Pending safeload goes first, still between passes
                if (s_q.go && sl_any) begin
                    s_d.st = dcm_pkg::ST_SAFE;
                end else if (s_q.pend) begin
                    s_d.st = dcm_pkg::ST_RUN;
                    s_d.pc = 10'h000;
                    s_d.il = s_q.nl;
                    s_d.ir = s_q.nr;
                    s_d.pend = samp_valid;
                end
            end
            dcm_pkg::ST_RUN: begin
                // One instruction per clock
                unique case (op)
                    dcm_pkg::OP_LDIN: s_d.acc = ch ? s_q.ir : s_q.il;
                    dcm_pkg::OP_LDD: s_d.acc = dword;
                    dcm_pkg::OP_MULP: s_d.acc = mulv;
                    dcm_pkg::OP_ACCD: s_d.acc = s_q.acc + dword;
                    dcm_pkg::OP_OUT: begin
                        if (ch) begin
                            s_d.orr = clip_v;
                        end else begin
                            s_d.ol = clip_v;
                        end
                    end
                    default: s_d.acc = s_q.acc;
                endcase
                // Held in clear while the core is not running
                if (!core_run) begin
                    s_d.acc = 28'h0000000;
                end
                s_d.pc = s_q.pc + 10'h001;
                if (s_q.pc == last_pc) begin
                    // Frame end: publish, step the delay ring
                    s_d.pc = 10'h000;
                    s_d.base = s_q.base - 11'h001;
                    s_d.out_valid = 1'b1;
                    if (unmute) begin
                        s_d.out_l = (op == dcm_pkg::OP_OUT && !ch) ? clip_v : s_q.ol;
                        s_d.out_r = (op == dcm_pkg::OP_OUT && ch) ? clip_v : s_q.orr;
                    end
                    s_d.st = (s_q.go && sl_any) ? dcm_pkg::ST_SAFE : dcm_pkg::ST_IDLE;
                end
            end
            dcm_pkg::ST_SAFE: begin
                // One entry per clock unless a host write takes the port; five entries take six clocks
                // Leave once every valid entry has been copied
                if (!sl_any) begin
                    s_d.st = dcm_pkg::ST_IDLE;
                    s_d.go = slreq.commit;
                end
            end
        endcase
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign out_l = s_q.out_l;
    assign out_r = s_q.out_r;
    assign out_valid = s_q.out_valid;
    assign host_rvalid = s_q.rvalid;
    assign host_rdata = s_q.rdata;
    assign ready = s_q.ready;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence pass_last;
        s_q.st == dcm_pkg::ST_RUN && s_q.pc == last_pc;
    endsequence

    sequence pass_over;
        s_q.st != dcm_pkg::ST_RUN && s_q.out_valid;
    endsequence

    a_pass_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pass_last |=> pass_over)
        else $error("pass did not end after last slot");
    a_pass_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(s_q.st == dcm_pkg::ST_RUN) |-> s_q.pc == 10'h000)
        else $error("pass did not start at slot zero");
    a_safe_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_q.st == dcm_pkg::ST_RUN && pram_we |-> host_pwe && !sl_we)
        else $error("safeload copy during a pass");
    a_safe_param: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sl_we |-> !prog_we && pram_we && pram_wd[31:28] == 4'h0)
        else $error("safeload reached beyond parameter memory");
    a_out_muted: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !unmute |=> out_l == 24'h000000 && out_r == 24'h000000)
        else $error("output not muted");
    a_burst_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hact |=> s_q.haddr == $past(eaddr) + 12'h001)
        else $error("burst address did not advance");
    a_steal_param: assert property (@(posedge ref_clk) disable iff (!rst_n)
        host_pwe |-> core_par == 28'h0000000)
        else $error("core saw parameter during host write");
    a_read_pad: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hact && !hreq.wr && eaddr <= dcm_pkg::PRAM_LAST |=>
        host_rvalid && host_rdata[39:28] == 12'h000)
        else $error("parameter read not zero padded");
    a_sext_in: assert property (@(posedge ref_clk) disable iff (!rst_n)
        samp_valid |=> s_q.nl == {{4{$past(samp_l[23])}}, $past(samp_l)})
        else $error("input not sign extended");
    a_safe_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(s_q.st == dcm_pkg::ST_SAFE) |-> ##[1:6] s_q.st != dcm_pkg::ST_SAFE)
        else $error("safeload copy too long");
endmodule

// [dv/dcm_host_mdl.sv]
// Host model on the core's control port
`timescale 1ns/100ps
module dcm_host_mdl (
    input wire logic ref_clk,
    input wire logic host_rvalid,
    input wire logic [39:0] host_rdata,
    output dcm_pkg::dcm_hreq_t hreq
);
    initial hreq = '0;
    // One word held to its taking edge; a read with no answer gives x
    task automatic xfer(input logic wr, input logic fst, input logic [11:0] a,
        input logic [39:0] d, output logic [39:0] q);
        hreq <= '{1'b1, fst, wr, a, d};
        @(posedge ref_clk);
        #1 q = host_rvalid ? host_rdata : 'x;
    endtask
    // Released port shows inverted address and data
    task automatic idle();
        hreq <= {1'b0, 2'h0, ~hreq[51:0]};
    endtask
endmodule

// [dv/tb.sv]
// Self-checking bench for the audio core datapath
`timescale 1ns/100ps
module tb;
    // ---------------------------------------------------------------
    // Signals, tables and counters
    // ---------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    dcm_pkg::dcm_hreq_t hreq;
    dcm_pkg::dcm_slreq_t slreq = '0;
    logic samp_valid = 1'b0;
    logic [23:0] samp_l = 24'h0;
    logic [23:0] samp_r = 24'h0;
    logic [1:0] rate_sel = 2'h0;
    logic core_run = 1'b1;
    logic unmute = 1'b0;
    logic [23:0] out_l, out_r;
    logic out_valid, host_rvalid, ready;
    logic [39:0] host_rdata, q;
    logic [31:0] seed = 32'h053A;
    logic [39:0] boot[6] = '{40'h0, dcm_pkg::DEF_P0, dcm_pkg::DEF_P1, dcm_pkg::DEF_P2,
        dcm_pkg::DEF_P3, 40'h0};
    // Gain program: in, multiply by parameter 0x3FF, out, per channel
    logic [39:0] prog[7] = '{40'hABC0800000, 40'h1000000000, 40'h30000003FF,
        40'h6000000000, 40'h1100000000, 40'h30000003FF, 40'h6100000000};
    logic [27:0] gains[4] = '{28'h0800000, 28'h4000000, 28'hC000000, 28'h0200000};
    int fail_count = 0;
    int cmp_count = 0;
    int i;
    always #4 ref_clk = ~ref_clk;
    dcm_core u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .hreq(hreq), .slreq(slreq),
        .samp_valid(samp_valid), .samp_l(samp_l), .samp_r(samp_r), .rate_sel(rate_sel),
        .core_run(core_run), .unmute(unmute), .out_l(out_l), .out_r(out_r),
        .out_valid(out_valid), .host_rvalid(host_rvalid), .host_rdata(host_rdata),
        .ready(ready));
    dcm_host_mdl u_host (.ref_clk(ref_clk), .host_rvalid(host_rvalid),
        .host_rdata(host_rdata), .hreq(hreq));
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Sign-extend, scale, keep bits 50:23, saturate to 24 bits
    function automatic logic [23:0] expect_out(input logic [23:0] s, input logic [27:0] g);
        logic signed [55:0] p;
        p = $signed({{4{s[23]}}, s}) * $signed(g);
        if ($signed(p[50:23]) > $signed(28'h07FFFFF)) return 24'h7FFFFF;
        if ($signed(p[50:23]) < $signed(28'hF800000)) return 24'h800000;
        return p[46:23];
    endfunction
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Safeload port, one cycle per call
    task automatic sl(input logic w, input logic [2:0] x, input logic [27:0] d, input logic c);
        slreq <= '{w, x, 10'h3FF, d, c};
        @(posedge ref_clk);
        #1;
    endtask
    // One sample pass: count cycles to the output strobe, check outputs
    task automatic pass(input logic [23:0] l, input logic [23:0] r, input logic [27:0] g,
        input int n);
        int k;
        repeat (8) @(posedge ref_clk);
        #1 samp_l <= l;
        samp_r <= r;
        samp_valid <= 1'b1;
        @(posedge ref_clk);
        #1 samp_valid <= 1'b0;
        for (k = 1; k < 1100 && out_valid !== 1'b1; k++) begin
            @(posedge ref_clk);
            #1;
        end
        chk("pass length", n, k);
        chk("out left", unmute ? expect_out(l, g) : 24'h0, out_l);
        chk("out right", unmute ? expect_out(r, g) : 24'h0, out_r);
        if (k == 1100) give_verdict();
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        #1 rst_n <= 1'b1;
        for (i = 0; i < 2100 && ready !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk("ready", 1, ready);
        if (ready !== 1'b1) give_verdict();
        for (i = 0; i < 6; i++) begin
            u_host.xfer(1'b0, i == 0, 12'h3FF, 40'h0, q);
            chk("boot", boot[i], q);
        end
        u_host.xfer(1'b1, 1'b1, 12'h800, 40'h5, q);
        u_host.xfer(1'b0, 1'b1, 12'h800, 40'h0, q);
        chk("unmapped", 40'h0, q);
        u_host.idle();
        for (i = 0; i < 4; i++) begin
            rate_sel <= i[1:0];
            unmute <= i > 0;
            pass(24'(rnd()), 24'(rnd()), gains[0], (1024 >> (i > 1 ? 2 : i)) + 2);
        end
        rate_sel <= 2'h0;
        core_run <= 1'b0;
        for (i = 0; i < 7; i++) u_host.xfer(1'b1, i == 0, 12'h3FF, prog[i], q);
        u_host.xfer(1'b0, 1'b1, 12'h3FF, 40'h0, q);
        chk("param pad", 40'h0000800000, q);
        u_host.idle();
        core_run <= 1'b1;
        for (i = 0; i < 4; i++) begin
            sl(1'b1, 3'h5, 28'h5A5A5A5, 1'b0);
            sl(1'b1, i[2:0], gains[i], 1'b0);
            sl(1'b0, 3'h0, 28'h0, 1'b1);
            slreq <= {1'b0, ~slreq[41:1], 1'b0};
            pass(24'(rnd()), i[0] ? 24'h800000 : 24'h7FFFFF, gains[i], 1026);
        end
        give_verdict();
    end
endmodule
